/* verilog/stp_pkg.sv */
// stp_pkg: constants and carrier types for the self test and output control block.
// assumes a single 20 MHz clock and memories with one-cycle registered read data.
package stp_pkg;
    // ----------------------------------------
    // clock
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;

    // ----------------------------------------
    // self test mode field
    // ----------------------------------------
    localparam logic [1:0] POWER_ON_SELF_TEST_MODE_OFF = 2'h0;
    localparam logic [1:0] POWER_ON_SELF_TEST_MODE_MEM = 2'h1;

    // ----------------------------------------
    // memory geometry
    // ----------------------------------------
    localparam int RAM_AW = 4;
    localparam int MEM_AW = 6;
    localparam logic [MEM_AW-1:0] RAM_LAST = 6'h0F;
    localparam logic [MEM_AW-1:0] ROM_LAST = 6'h3F;
    localparam logic [MEM_AW-1:0] NVM_LAST = 6'h1F;

    // ----------------------------------------
    // ram test patterns
    // ----------------------------------------
    localparam logic [1:0] PAT_ADDR = 2'h0;
    localparam logic [1:0] PAT_ZERO = 2'h1;
    localparam logic [1:0] PAT_ONE = 2'h2;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'hFF;

    // ----------------------------------------
    // pwm duty limits, period of 256 clocks
    // ----------------------------------------
    localparam logic [7:0] DUTY_MIN = 8'h02;
    localparam logic [7:0] DUTY_MAX = 8'hFE;
    localparam logic [7:0] CNT_LAST = 8'hFF;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        ST_WAIT = 3'b000,
        ST_RAM_WR = 3'b001,
        ST_RAM_RD = 3'b010,
        ST_SUM = 3'b011,
        ST_DONE = 3'b100
    } stp_state_t;

    // ----------------------------------------
    // fault indications from detectors and signal path
    // ----------------------------------------
    typedef struct packed
    {
        logic overcurrent;
        logic undervoltage;
        logic overvoltage;
        logic overtemp;
        logic [2:0] pos_ovf;   // field adc, low pass, temp compensation
        logic [2:0] neg_ovf;   // field adc, low pass, temp compensation
        logic [1:0] temp_ovf;  // temp adc, calibrated temperature
    } stp_fault_t;
endpackage

/* verilog/stp_ram.sv */
// stp_ram: small byte-wide scratch ram under test.
// assumes one write or read per clock; read data come out one clock later.
`timescale 1ns/1ns
module stp_ram
(
    // clock
    input wire logic mclk,
    // access
    input wire logic we,
    input wire logic [stp_pkg::RAM_AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    import stp_pkg::*;

    logic [7:0] mem_reg [0:(1<<RAM_AW)-1];

    always_ff @(posedge mclk)
    begin
        if (we)
        begin
            mem_reg[addr] <= wdata;
        end
        rdata <= mem_reg[addr];
    end
endmodule

/* verilog/stp_selftest.sv */
// stp_selftest: power-on memory self test and pwm output control with fault overrides.
// assumes synchronous fault inputs, rom and nvm reads with one clock of latency,
// and an external pull-up on the open-drain pin.
`timescale 1ns/1ns
// How it works
// - mode 00 skips the self test; mode 01 runs ram, rom and nvm tests.
// - the self test starts as soon as supply good asserts.
// - output stays off while the test runs; enabled once it completes.
// - any failed check forces minimum duty at once.
// - ram address test writes each address value, reads back, catches aliasing.
// - ram cell test writes and checks all zeros then all ones.
// - rom bytes summed into 8 bits, compared with stored rom checksum byte.
// - checksum mismatch flags a self test error.
// - nvm gets same byte sum, reference from its dedicated checksum byte.
// - overcurrent turns pin high impedance until the next low pulse begins.
// - undervoltage or overvoltage puts the pin high impedance.
// - over-temperature indication puts the pin high impedance until it clears.
// - positive signal path overflow forces maximum duty unless a failure, negative or temperature overflow forces minimum.
// - negative signal path overflow forces minimum duty.
// - temperature path overflow either way forces minimum duty.
// - in normal operation the pin carries a continuous pwm signal.
module stp_selftest
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // configuration and supply
    input wire logic supply_good,
    input wire logic [1:0] power_on_self_test_mode,
    // signal path
    input wire logic [7:0] meas_duty,
    input wire stp_pkg::stp_fault_t faults,
    // rom and nvm read port
    output logic [stp_pkg::MEM_AW-1:0] mem_addr,
    input wire logic [7:0] rom_rdata,
    input wire logic [7:0] nvm_rdata,
    // pin
    output logic pin_out,
    output logic pin_oe_n,
    // status
    output logic power_on_self_test_busy,
    output logic power_on_self_test_fail
);
    import stp_pkg::*;

    stp_state_t state_reg;
    logic [MEM_AW-1:0] idx_reg;
    logic [1:0] pat_reg;
    logic nvm_sel_reg;
    logic stop_reg;
    logic [7:0] sum_reg;
    logic pend_reg;
    logic [MEM_AW-1:0] pidx_reg;
    logic ram_pend_reg;
    logic [1:0] ppat_reg;
    logic fail_reg;
    logic ram_we;
    logic [7:0] ram_wdata;
    logic [7:0] ram_rdata;
    logic [7:0] ram_exp;
    logic [7:0] sum_data;
    logic [MEM_AW-1:0] sum_last;
    logic chk_now;
    logic ram_bad;
    logic sum_bad;
    logic [7:0] cnt_reg;
    logic [7:0] duty_cur_reg;
    logic [7:0] duty_sel;
    logic oc_reg;
    logic hiz;
    logic pwm_high;

    function automatic logic [7:0] pat_byte(input logic [1:0] pat, input logic [MEM_AW-1:0] a);
        logic [7:0] v;
        v = BYTE_ONE;
        if (pat == PAT_ADDR)
        begin
            v = {2'b00, a};
        end
        else if (pat == PAT_ZERO)
        begin
            v = BYTE_ZERO;
        end
        return v;
    endfunction

    // ----------------------------------------
    // ram under test
    // ----------------------------------------
    assign ram_we = (state_reg == ST_RAM_WR);
    assign ram_wdata = pat_byte(pat_reg, idx_reg);
    assign ram_exp = pat_byte(ppat_reg, pidx_reg);

    stp_ram u_ram
    (
        .mclk(mclk),
        .we(ram_we),
        .addr(idx_reg[RAM_AW-1:0]),
        .wdata(ram_wdata),
        .rdata(ram_rdata)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    assign mem_addr = idx_reg;
    assign sum_data = nvm_sel_reg ? nvm_rdata : rom_rdata;
    assign sum_last = nvm_sel_reg ? NVM_LAST : ROM_LAST;
    assign chk_now = pend_reg && (state_reg == ST_SUM) && (pidx_reg == sum_last);
    assign ram_bad = ram_pend_reg && (ram_rdata != ram_exp);
    assign sum_bad = chk_now && (sum_reg != sum_data);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_WAIT;
            idx_reg <= '0;
            pat_reg <= PAT_ADDR;
            nvm_sel_reg <= 1'b0;
            stop_reg <= 1'b0;
            sum_reg <= BYTE_ZERO;
            pend_reg <= 1'b0;
            pidx_reg <= '0;
            ram_pend_reg <= 1'b0;
            ppat_reg <= PAT_ADDR;
        end
        else
        begin
            pend_reg <= 1'b0;
            ram_pend_reg <= 1'b0;
            case (state_reg)
                ST_WAIT:
                begin
                    if (supply_good)
                    begin
                        state_reg <= (power_on_self_test_mode == POWER_ON_SELF_TEST_MODE_MEM) ? ST_RAM_WR : ST_DONE;
                    end
                end
                ST_RAM_WR:
                begin
                    idx_reg <= (idx_reg == RAM_LAST) ? '0 : idx_reg + 6'h01;
                    if (idx_reg == RAM_LAST)
                    begin
                        state_reg <= ST_RAM_RD;
                    end
                end
                ST_RAM_RD:
                begin
                    // pattern travels with the read, pat_reg moves on at the last address
                    ram_pend_reg <= 1'b1;
                    ppat_reg <= pat_reg;
                    pidx_reg <= idx_reg;
                    idx_reg <= (idx_reg == RAM_LAST) ? '0 : idx_reg + 6'h01;
                    if (idx_reg == RAM_LAST)
                    begin
                        // three passes: address values, zeros, ones
                        state_reg <= (pat_reg == PAT_ONE) ? ST_SUM : ST_RAM_WR;
                        pat_reg <= pat_reg + 2'h1;
                    end
                end
                ST_SUM:
                begin
                    if (!stop_reg)
                    begin
                        pend_reg <= 1'b1;
                        pidx_reg <= idx_reg;
                        idx_reg <= idx_reg + 6'h01;
                        stop_reg <= (idx_reg == sum_last);
                    end
                    // the last byte holds the reference and is not summed
                    if (pend_reg && !chk_now)
                    begin
                        sum_reg <= sum_reg + sum_data;
                    end
                    if (chk_now)
                    begin
                        sum_reg <= BYTE_ZERO;
                        idx_reg <= '0;
                        stop_reg <= 1'b0;
                        nvm_sel_reg <= 1'b1;
                        if (nvm_sel_reg)
                        begin
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_DONE:
                begin
                    state_reg <= ST_DONE;
                end
                default:
                begin
                    state_reg <= ST_WAIT;
                end
            endcase
        end
    end

    // ----------------------------------------
    // failure latch, cleared only by reset
    // ----------------------------------------
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fail_reg <= 1'b0;
        end
        else if (ram_bad || sum_bad)
        begin
            fail_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // duty selection
    // ----------------------------------------
    always_comb
    begin
        duty_sel = meas_duty;
        if (meas_duty < DUTY_MIN)
        begin
            duty_sel = DUTY_MIN;
        end
        else if (meas_duty > DUTY_MAX)
        begin
            duty_sel = DUTY_MAX;
        end
        // minimum wins over maximum: a suspect device should read as low
        if (|faults.pos_ovf)
        begin
            duty_sel = DUTY_MAX;
        end
        if (fail_reg || (|faults.neg_ovf) || (|faults.temp_ovf))
        begin
            duty_sel = DUTY_MIN;
        end
    end

    // ----------------------------------------
    // pwm and pin
    // ----------------------------------------
    assign pwm_high = (cnt_reg < duty_cur_reg);
    assign hiz = (state_reg != ST_DONE) || oc_reg || faults.undervoltage
               || faults.overvoltage || faults.overtemp;

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg <= '0;
            duty_cur_reg <= DUTY_MIN;
        end
        else
        begin
            cnt_reg <= cnt_reg + 8'h01;
            // a failure's minimum duty takes over mid-period so it shows at once; overflow-forced duties wait for the period end
            if (cnt_reg == CNT_LAST || fail_reg || ram_bad || sum_bad)
            begin
                duty_cur_reg <= duty_sel;
            end
        end
    end

    // overcurrent release at the start of the next low pulse; a new event wins
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            oc_reg <= 1'b0;
        end
        else if (faults.overcurrent)
        begin
            oc_reg <= 1'b1;
        end
        else if (cnt_reg == duty_cur_reg)
        begin
            oc_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            power_on_self_test_busy <= 1'b1;
            power_on_self_test_fail <= 1'b0;
        end
        else
        begin
            pin_out <= 1'b0;
            pin_oe_n <= hiz || pwm_high;
            power_on_self_test_busy <= (state_reg != ST_DONE);
            power_on_self_test_fail <= fail_reg;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    start_on_supply_a: assert property ((state_reg == ST_WAIT) && supply_good && (power_on_self_test_mode == POWER_ON_SELF_TEST_MODE_MEM)
        |=> state_reg == ST_RAM_WR) else $error("self test did not start");
    mode_off_skip_a: assert property ((state_reg == ST_WAIT) && supply_good && (power_on_self_test_mode == POWER_ON_SELF_TEST_MODE_OFF)
        |=> state_reg == ST_DONE) else $error("disabled self test ran");
    busy_pin_off_a: assert property ((state_reg != ST_DONE) |=> pin_oe_n) else $error("pin driven in test");
    fail_min_duty_a: assert property (fail_reg |-> duty_sel == DUTY_MIN) else $error("fail not min duty");
    fail_sticky_a: assert property (fail_reg |=> fail_reg && power_on_self_test_fail) else $error("fail latch dropped");
    ram_mismatch_fail_a: assert property (ram_bad |=> fail_reg) else $error("ram error missed");
    sum_mismatch_fail_a: assert property (sum_bad |=> fail_reg ##1 power_on_self_test_fail) else $error("sum error missed");
    oc_hiz_a: assert property (faults.overcurrent |-> ##2 pin_oe_n) else $error("overcurrent drove pin");
    oc_release_a: assert property (oc_reg && !faults.overcurrent && (cnt_reg == duty_cur_reg)
        |=> !oc_reg) else $error("overcurrent not released");
    supply_hiz_a: assert property ((faults.undervoltage || faults.overvoltage) |=> pin_oe_n)
        else $error("supply fault drove pin");
    hot_hiz_a: assert property (faults.overtemp |=> pin_oe_n) else $error("overtemp drove pin");
    pos_ovf_max_a: assert property ((|faults.pos_ovf) && !fail_reg && !(|faults.neg_ovf) && !(|faults.temp_ovf)
        |-> duty_sel == DUTY_MAX) else $error("pos overflow not max");
    neg_ovf_min_a: assert property ((|faults.neg_ovf) |-> duty_sel == DUTY_MIN) else $error("neg overflow");
    temp_ovf_min_a: assert property ((|faults.temp_ovf) |-> duty_sel == DUTY_MIN) else $error("temp ovf");
    pwm_low_phase_a: assert property (!hiz && !pwm_high |=> !pin_oe_n) else $error("pwm low missing");

    pass_c: cover property ((state_reg == ST_SUM) ##1 (state_reg == ST_DONE) && !fail_reg);
    fail_c: cover property ($rose(fail_reg));
    oc_c: cover property ($rose(oc_reg) ##[1:300] $fell(oc_reg));
endmodule

/* dv/stp_ecu_model.sv */
// stp_rx_model: receiving controller that decodes the pwm pin through its pull-up.
// assumes the bench resolves the open-drain line and that it is sampled on mclk.
`timescale 1ns/1ns
module stp_rx_model
(
    // clock
    input wire logic mclk,
    // resolved line
    input wire logic pin_line,
    // decoded period
    output logic [9:0] hi_len,
    output logic [9:0] per_len,
    output logic meas_stb,
    output logic stuck_high
);
    logic prev_line;
    logic armed;
    logic [9:0] hi_cnt;
    logic [9:0] per_cnt;

    initial
    begin
        {prev_line, armed, meas_stb, stuck_high} = 4'h0;
        {hi_cnt, per_cnt, hi_len, per_len} = 40'h0;
    end

    // ------------------------------------------------
    // period decoding, rising edge to rising edge
    // ------------------------------------------------
    always @(posedge mclk)
    begin
        meas_stb <= 1'b0;
        prev_line <= pin_line;
        if (pin_line && !prev_line)
        begin
            // first rise after a disturbance only restarts timing
            if (armed && !stuck_high)
            begin
                hi_len <= hi_cnt;
                per_len <= per_cnt;
                meas_stb <= 1'b1;
            end
            armed <= 1'b1;
            stuck_high <= 1'b0;
            hi_cnt <= 10'h001;
            per_cnt <= 10'h001;
        end
        else
        begin
            per_cnt <= per_cnt + 10'(per_cnt != 10'h3FF);
            hi_cnt <= hi_cnt + 10'(pin_line && hi_cnt != 10'h3FF);
            // high for over a full period: supply or ground wire is broken
            if (pin_line && hi_cnt > 10'h100)
                stuck_high <= 1'b1;
        end
    end
endmodule

/* dv/stp_selftest_tb_top.sv */
// stp_selftest_tb_top: self-checking bench for self test and pin control.
// assumes a pull-up on the pin and rom/nvm that answer one clock after the address.
`timescale 1ns/1ns
module stp_selftest_tb_top;
    import stp_pkg::*;
    logic mclk;
    logic sys_rst;
    logic supply_good;
    logic [1:0] power_on_self_test_mode;
    logic [7:0] meas_duty;
    stp_fault_t faults;
    logic [MEM_AW-1:0] mem_addr;
    logic [7:0] rom_rdata;
    logic [7:0] nvm_rdata;
    logic pin_out;
    logic pin_oe_n;
    logic power_on_self_test_busy;
    logic power_on_self_test_fail;
    logic pin_line;
    logic [9:0] hi_len;
    logic [9:0] per_len;
    logic meas_stb;
    logic stuck_high;
    logic [7:0] rom_mem [64];
    logic [7:0] nvm_mem [32];
    int miscompares;
    int n_checks;

    // ------------------------------------------------
    // clock, pull-up, memories
    // ------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    assign pin_line = pin_oe_n ? 1'b1 : pin_out;
    always @(posedge mclk)
    begin
        rom_rdata <= rom_mem[mem_addr];
        nvm_rdata <= nvm_mem[mem_addr[4:0]];
    end

    stp_selftest dut (.mclk(mclk), .sys_rst(sys_rst), .supply_good(supply_good), .power_on_self_test_mode(power_on_self_test_mode),
        .meas_duty(meas_duty), .faults(faults), .mem_addr(mem_addr), .rom_rdata(rom_rdata),
        .nvm_rdata(nvm_rdata), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .power_on_self_test_busy(power_on_self_test_busy),
        .power_on_self_test_fail(power_on_self_test_fail));
    stp_rx_model u_rx (.mclk(mclk), .pin_line(pin_line), .hi_len(hi_len), .per_len(per_len),
        .meas_stb(meas_stb), .stuck_high(stuck_high));

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic tick();
        @(posedge mclk);
        #5;
    endtask

    task automatic check(input string what, input logic [9:0] expv, input logic [9:0] got);
        n_checks++;
        if (got !== expv)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic fill(input logic bad_rom, input logic bad_nvm);
        logic [7:0] sum_r;
        logic [7:0] sum_n;
        sum_r = 8'h00;
        sum_n = 8'h00;
        for (int i = 0; i < 63; i++)
        begin
            rom_mem[i] = 8'(i * 37 + 5);
            sum_r += rom_mem[i];
        end
        for (int i = 0; i < 31; i++)
        begin
            nvm_mem[i] = 8'(i * 91 + 17);
            sum_n += nvm_mem[i];
        end
        rom_mem[63] = sum_r ^ {7'h00, bad_rom};
        nvm_mem[31] = sum_n ^ {7'h00, bad_nvm};
    endtask

    // several periods, because duty changes land at a period boundary unless a failure forces minimum duty
    task automatic measure(input logic [7:0] exp_duty);
        int seen;
        seen = 0;
        for (int n = 0; n < 1100 && seen < 3; n++)
        begin
            tick();
            seen += int'(meas_stb === 1'b1);
        end
        check("pwm periods seen", 10'h003, 10'(seen));
        check("pwm period", 10'h100, per_len);
        check("pwm high time", 10'(exp_duty), hi_len);
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic run_power_on_self_test(input logic [1:0] mode, input logic bad_rom, input logic bad_nvm);
        int n;
        int drv;
        logic exp_fail;
        exp_fail = (mode == POWER_ON_SELF_TEST_MODE_MEM) && (bad_rom || bad_nvm);
        n = 0;
        drv = 0;
        fill(bad_rom, bad_nvm);
        power_on_self_test_mode = mode;
        meas_duty = 8'h60;
        sys_rst = 1'b1;
        supply_good = 1'b0;
        faults = '0;
        repeat (10) tick();
        check("busy in reset", 10'h001, 10'(power_on_self_test_busy));
        check("pin in reset", 10'h001, 10'(pin_oe_n));
        sys_rst = 1'b0;
        repeat (20) tick();
        check("busy before supply", 10'h001, 10'(power_on_self_test_busy));
        supply_good = 1'b1;
        while (power_on_self_test_busy !== 1'b0 && n < 400)
        begin
            drv += int'(pin_oe_n !== 1'b1);
            n++;
            tick();
        end
        check("test finished", 10'h001, 10'(n < 400));
        check("pin driven in test", 10'h000, 10'(drv));
        check("memory test ran", 10'(mode == POWER_ON_SELF_TEST_MODE_MEM), 10'(n > 120));
        check("fail flag", 10'(exp_fail), 10'(power_on_self_test_fail));
        supply_good = 1'b0;
        meas_duty = 8'hA0;
        measure(exp_fail ? DUTY_MIN : 8'hA0);
        check("fail held", 10'(exp_fail), 10'(power_on_self_test_fail));
    endtask

    task automatic forced_duty();
        for (int i = 0; i < 9; i++)
        begin
            faults = '0;
            if (i < 3)
                faults.pos_ovf[i] = 1'b1;
            else if (i < 6)
                faults.neg_ovf[i - 3] = 1'b1;
            else if (i < 8)
                faults.temp_ovf[i - 6] = 1'b1;
            else
            begin
                faults.pos_ovf = 3'h7;
                faults.neg_ovf = 3'h1;
            end
            measure(i < 3 ? DUTY_MAX : DUTY_MIN);
        end
        faults = '0;
    endtask

    task automatic release_faults();
        int drv;
        for (int k = 0; k < 3; k++)
        begin
            drv = 0;
            faults = '0;
            faults.pos_ovf = 3'h1;
            faults.undervoltage = (k == 0);
            faults.overvoltage = (k == 1);
            faults.overtemp = (k == 2);
            repeat (2) tick();
            repeat (300)
            begin
                drv += int'(pin_oe_n !== 1'b1);
                tick();
            end
            check("pin released", 10'h000, 10'(drv));
            check("line stuck high", 10'h001, 10'(stuck_high));
            faults = '0;
            measure(8'hA0);
        end
    endtask

    task automatic overcurrent_hit();
        int n;
        n = 0;
        while (pin_oe_n !== 1'b0 && n < 300)
        begin
            tick();
            n++;
        end
        faults.overcurrent = 1'b1;
        tick();
        faults.overcurrent = 1'b0;
        tick();
        check("pin off on overcurrent", 10'h001, 10'(pin_oe_n));
        n = 0;
        while (pin_oe_n !== 1'b0 && n < 300)
        begin
            tick();
            n++;
        end
        check("pin back by next low", 10'h001, 10'(n < 300));
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------
    initial
    begin
        miscompares = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        supply_good = 1'b0;
        power_on_self_test_mode = POWER_ON_SELF_TEST_MODE_OFF;
        meas_duty = 8'h60;
        faults = '0;
        for (int m = 0; m < 4; m++)
            run_power_on_self_test(2'(m), 1'b0, 1'b0);
        forced_duty();
        release_faults();
        overcurrent_hit();
        run_power_on_self_test(POWER_ON_SELF_TEST_MODE_MEM, 1'b1, 1'b0);
        run_power_on_self_test(POWER_ON_SELF_TEST_MODE_MEM, 1'b0, 1'b1);
        final_report();
    end

    // about five times the expected run length
    initial
    begin
        #4_000_000;
        miscompares++;
        final_report();
    end
endmodule
